// File: dtd_map.svh
`ifndef DTD_MAP_SVH
`define DTD_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTD_OFS_CTRL 8'h00
`define DTD_OFS_BURST 8'h04
`define DTD_OFS_DELAY 8'h08
`define DTD_OFS_XFER 8'h0C
`define DTD_OFS_DEMAND 8'h14
`define DTD_OFS_IRQMASK 8'h18

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define DTD_CTL_OFL 12
`define DTD_CTL_CLR 11
`define DTD_CTL_PND 10
`define DTD_CTL_DMDENA 9
`define DTD_CTL_INTDEN 7
`define DTD_CTL_DLYENA 5
`define DTD_CTL_BSTENA 4

// ----------------------------------------------------------------------
// Field widths, sizes and reset values
// ----------------------------------------------------------------------
`define DTD_BURST_W 8
`define DTD_DELAY_W 16
`define DTD_IRQ_W 7
`define DTD_CODE_W 4
`define DTD_TRIG_W 12
`define DTD_XFER_W 32
`define DTD_DEMAND_DEPTH 2048
`define DTD_BURST_MAX 9'h100
`define DTD_CSR_RST 1'b0
`define DTD_BURST_RST 8'h00
`define DTD_DELAY_RST 16'h0000
`define DTD_IRQMASK_RST 7'h00
`define DTD_XFER_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DTD_CLK_NS 100
`define DTD_TICK_NS 200
`define DTD_LAT_NS 500
`define DTD_TICK_CYC ((`DTD_TICK_NS + `DTD_CLK_NS - 1) / `DTD_CLK_NS)
`define DTD_LAT_CYC ((`DTD_LAT_NS + `DTD_CLK_NS - 1) / `DTD_CLK_NS)

`endif

// File: dtd_pkg.sv
`default_nettype none
`include "dtd_map.svh"

package dtd_pkg;
   typedef logic [`DTD_CODE_W-1:0] dtd_code_type;
   typedef logic [`DTD_TRIG_W-1:0] dtd_trig_type;
   typedef enum logic [1:0] {DLY_IDLE, DLY_LAT, DLY_COUNT, DLY_DRIVE}
      dtd_dly_state_type;
endpackage : dtd_pkg

`default_nettype wire

// File: dtd_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtd_map.svh"

interface dtd_fifo_if;
   import dtd_pkg::*;
   logic clear;
   logic push;
   dtd_code_type push_data;
   logic pop;
   dtd_code_type pop_data;
   logic empty;
   logic full;
   modport fifo (input clear, push, push_data, pop,
                 output pop_data, empty, full);
   modport user (output clear, push, push_data, pop,
                 input pop_data, empty, full);
endinterface : dtd_fifo_if

`default_nettype wire

// File: dtd_demand_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtd_map.svh"

module dtd_demand_fifo #(
   parameter int DEPTH = `DTD_DEMAND_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   dtd_fifo_if.fifo q
);
   import dtd_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   dtd_code_type mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   // Full refuses the push, so the caller sees the drop and flags it.
   assign do_push = q.push && (count_r != FULL_CNT) && !q.clear;
   assign do_pop = q.pop && (count_r != '0) && !q.clear;
   assign q.empty = (count_r == '0);
   assign q.full = (count_r == FULL_CNT);
   assign q.pop_data = mem[rd_ptr_r];

   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[wr_ptr_r] <= q.push_data;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (q.clear)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_r + AW'(do_push);
         rd_ptr_r <= rd_ptr_r + AW'(do_pop);
         count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_full_holds: assert property (
      q.full && q.push && !q.pop && !q.clear |=> q.full && $stable(wr_ptr_r))
      else $error("Push into a full queue was stored.");

   a_clear_empty: assert property (
      q.clear |=> q.empty)
      else $error("Clear left entries in the queue.");
endmodule : dtd_demand_fifo

`default_nettype wire

// File: dtd_trig_delay.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtd_map.svh"

module dtd_trig_delay (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic dly_en,
   input wire logic [`DTD_DELAY_W-1:0] count,
   input wire dtd_pkg::dtd_trig_type mask,
   output dtd_pkg::dtd_trig_type trig
);
   import dtd_pkg::*;
   localparam logic [3:0] LAT_LAST = 4'(`DTD_LAT_CYC - 1);
   localparam logic [1:0] TICK_LAST = 2'(`DTD_TICK_CYC - 1);
   dtd_dly_state_type state_r;
   logic [`DTD_DELAY_W-1:0] cnt_r;
   logic [3:0] lat_r;
   logic [1:0] tick_r;
   dtd_trig_type trig_r;

   assign trig = trig_r;

   // A trigger arriving while one is in flight is dropped, not queued.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= DLY_IDLE;
         cnt_r <= `DTD_DELAY_RST;
         lat_r <= '0;
         tick_r <= '0;
         trig_r <= '0;
      end
      else
      begin
         unique case (state_r)
            DLY_IDLE:
               if (start && dly_en)
               begin
                  cnt_r <= count;
                  lat_r <= LAT_LAST;
                  state_r <= DLY_LAT;
               end
               else if (start)
               begin
                  trig_r <= mask;
                  tick_r <= TICK_LAST;
                  state_r <= DLY_DRIVE;
               end
            DLY_LAT:
               if (lat_r != '0)
               begin
                  lat_r <= lat_r - 4'd1;
               end
               else if (cnt_r == '0)
               begin
                  trig_r <= mask;
                  tick_r <= TICK_LAST;
                  state_r <= DLY_DRIVE;
               end
               else
               begin
                  tick_r <= TICK_LAST;
                  state_r <= DLY_COUNT;
               end
            DLY_COUNT:
               if (tick_r != '0)
               begin
                  tick_r <= tick_r - 2'd1;
               end
               else if (cnt_r == 16'h0001)
               begin
                  trig_r <= mask;
                  tick_r <= TICK_LAST;
                  state_r <= DLY_DRIVE;
               end
               else
               begin
                  cnt_r <= cnt_r - 16'h0001;
                  tick_r <= TICK_LAST;
               end
            DLY_DRIVE:
               if (tick_r != '0)
               begin
                  tick_r <= tick_r - 2'd1;
               end
               else
               begin
                  trig_r <= '0;
                  state_r <= DLY_IDLE;
               end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_go(logic [15:0] c);
      state_r == DLY_IDLE && start && dly_en && count == c && mask != '0;
   endsequence
   sequence s_quiet_fire;
      (trig_r == '0)[*5] ##1 (trig_r == $past(mask));
   endsequence

   a_fixed_latency: assert property (
      s_go(16'h0000) |=> s_quiet_fire)
      else $error("Zero count did not fire after the fixed latency.");

   a_one_step: assert property (
      s_go(16'h0001) |=> (trig_r == '0)[*2] ##1 s_quiet_fire)
      else $error("One count did not add one tick of delay.");

   a_no_delay: assert property (
      state_r == DLY_IDLE && start && !dly_en |=> trig_r == $past(mask))
      else $error("Disabled delay did not drive at once.");
endmodule : dtd_trig_delay

`default_nettype wire

// File: dtd_regs.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dtd_map.svh"

// Operation
// - Burst limit bits 7-0 bound bus tenure
// - Broadcast trigger loads delay, counts to end
// - Count done drives broadcast mask outputs
// - Delay disabled drives mask outputs at once
// - One count equals one 200 ns tick
// - Fixed 500 ns latency before sourcing
// - Delay count 16-bit write-only at 08
// - Command count loads transfer counter, read 0C
// - Increment counter per transfer until exhausted
// - Counter holds two's complement of remaining
// - Demand queue read-only at 14, 2048 deep
// - Interrupt demand enable queues each interrupt
// - Entry stays until read or sent
// - Message enable off stops messages, keeps queuing
// - Pending flag set while queue not empty
// - Demand into full queue dropped, overflow set
// - Overflow sticky; clear bit empties and clears
// - Entry bits 3-0 hold level 1 to 7
// - Mask at 18 selects watched lines 7-1
// - Delay enable is control bit 5
module dtd_regs (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Highway side
   input wire logic CMD_LOAD,
   input wire logic [31:0] CMD_COUNT,
   input wire logic BCAST_TRIG,
   input wire dtd_pkg::dtd_trig_type BCAST_MASK,
   input wire logic DMD_MSG_ACCEPT,
   output logic DMD_MSG_VALID,
   output dtd_pkg::dtd_code_type DMD_MSG_CODE,
   // VXI side
   input wire logic XFER_DONE,
   input wire logic [7:1] IRQ_N,
   output logic XFER_RUN,
   output logic BUS_RELEASE,
   output dtd_pkg::dtd_trig_type TRIG_OUT,
   // Status
   output logic DMD_PENDING,
   output logic DMD_OVERFLOW
);
   import dtd_pkg::*;

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   logic bus_take;
   logic acc_pend_r;
   logic acc_write_r;
   logic [7:0] acc_addr_r;
   logic hready_r;
   logic [31:0] hrdata_r;
   logic hresp_r;
   logic wr_en;
   logic rd_en;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   // Only whole-word transfers are taken; others complete with no effect.
   assign bus_take = HSEL && HTRANS[1] && HREADY && (HSIZE == 3'h2);
   assign wr_en = acc_pend_r && acc_write_r;
   assign rd_en = acc_pend_r && !acc_write_r;

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         acc_pend_r <= 1'b0;
         acc_write_r <= 1'b0;
         acc_addr_r <= 8'h00;
         hready_r <= 1'b1;
         hresp_r <= 1'b0;
      end
      else
      begin
         acc_pend_r <= bus_take;
         hready_r <= !bus_take;
         hresp_r <= 1'b0;
         if (bus_take)
         begin
            acc_write_r <= HWRITE;
            acc_addr_r <= HADDR[7:0];
         end
      end
   end

   assign HREADYOUT = hready_r;
   assign HRESP = hresp_r;
   assign HRDATA = hrdata_r;

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   logic demand_message_enable_r;
   logic interrupt_demand_enable_r;
   logic delay_enable_r;
   logic burst_enable_r;
   logic [`DTD_BURST_W-1:0] burst_limit_r;
   logic [`DTD_DELAY_W-1:0] delay_count_r;
   logic [`DTD_IRQ_W-1:0] irq_mask_r;
   logic clr;

   assign clr = wr_en && hit(acc_addr_r, `DTD_OFS_CTRL)
      && HWDATA[`DTD_CTL_CLR];

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         demand_message_enable_r <= `DTD_CSR_RST;
         interrupt_demand_enable_r <= `DTD_CSR_RST;
         delay_enable_r <= `DTD_CSR_RST;
         burst_enable_r <= `DTD_CSR_RST;
         burst_limit_r <= `DTD_BURST_RST;
         delay_count_r <= `DTD_DELAY_RST;
         irq_mask_r <= `DTD_IRQMASK_RST;
      end
      else if (wr_en)
      begin
         if (hit(acc_addr_r, `DTD_OFS_CTRL))
         begin
            demand_message_enable_r <= HWDATA[`DTD_CTL_DMDENA];
            interrupt_demand_enable_r <= HWDATA[`DTD_CTL_INTDEN];
            delay_enable_r <= HWDATA[`DTD_CTL_DLYENA];
            burst_enable_r <= HWDATA[`DTD_CTL_BSTENA];
         end
         if (hit(acc_addr_r, `DTD_OFS_BURST))
         begin
            burst_limit_r <= HWDATA[`DTD_BURST_W-1:0];
         end
         if (hit(acc_addr_r, `DTD_OFS_DELAY))
         begin
            delay_count_r <= HWDATA[`DTD_DELAY_W-1:0];
         end
         if (hit(acc_addr_r, `DTD_OFS_IRQMASK))
         begin
            irq_mask_r <= HWDATA[`DTD_IRQ_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Transfer counter and burst tenure
   // ------------------------------------------------------------------
   logic [`DTD_XFER_W-1:0] xfer_r;
   logic [`DTD_XFER_W-1:0] xfer_nxt;
   logic xfer_run_r;
   logic [8:0] burst_cnt_r;
   logic [8:0] burst_lim;
   logic bus_release_r;

   // The counter runs up toward zero, so the read value stays the
   // negated remaining count even after an aborted operation.
   always_comb
   begin
      xfer_nxt = xfer_r;
      if (CMD_LOAD)
      begin
         xfer_nxt = CMD_COUNT;
      end
      else if (XFER_DONE && xfer_r != '0)
      begin
         xfer_nxt = xfer_r + 32'h0000_0001;
      end
   end

   // A zero limit stands for the full 256 transfers.
   assign burst_lim = (burst_limit_r == '0) ? `DTD_BURST_MAX
      : {1'b0, burst_limit_r};

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         xfer_r <= `DTD_XFER_RST;
         xfer_run_r <= 1'b0;
      end
      else
      begin
         xfer_r <= xfer_nxt;
         xfer_run_r <= (xfer_nxt != '0);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         burst_cnt_r <= '0;
         bus_release_r <= 1'b0;
      end
      else
      begin
         bus_release_r <= 1'b0;
         if (CMD_LOAD)
         begin
            burst_cnt_r <= '0;
         end
         else if (XFER_DONE)
         begin
            if (!burst_enable_r || burst_cnt_r + 9'h001 >= burst_lim
               || xfer_nxt == '0)
            begin
               bus_release_r <= 1'b1;
               burst_cnt_r <= '0;
            end
            else
            begin
               burst_cnt_r <= burst_cnt_r + 9'h001;
            end
         end
      end
   end

   assign XFER_RUN = xfer_run_r;
   assign BUS_RELEASE = bus_release_r;

   // ------------------------------------------------------------------
   // Broadcast trigger delay
   // ------------------------------------------------------------------
   dtd_trig_delay u_delay (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .start(BCAST_TRIG),
      .dly_en(delay_enable_r),
      .count(delay_count_r),
      .mask(BCAST_MASK),
      .trig(TRIG_OUT)
   );

   // ------------------------------------------------------------------
   // Interrupt demand capture
   // ------------------------------------------------------------------
   logic [`DTD_IRQ_W-1:0] irq_prev_r;
   logic [`DTD_IRQ_W-1:0] irq_wait_r;
   logic [`DTD_IRQ_W-1:0] irq_edge;
   logic [`DTD_IRQ_W-1:0] irq_done;
   logic push_req;
   dtd_code_type push_code;

   function automatic dtd_code_type pick_level(input logic [6:0] p);
      pick_level = '0;
      for (int i = 0; i < `DTD_IRQ_W; i++)
      begin
         if (p[i])
         begin
            pick_level = 4'(i + 1);
         end
      end
   endfunction : pick_level

   assign irq_edge = ~IRQ_N & ~irq_prev_r & irq_mask_r
      & {`DTD_IRQ_W{interrupt_demand_enable_r}};
   assign push_req = (irq_wait_r != '0);
   assign push_code = pick_level(irq_wait_r);
   assign irq_done = push_req ? (7'h01 << (push_code - 4'd1)) : 7'h00;

   // Several lines may assert together; they are queued one per cycle,
   // highest level first, and a new edge wins over the clear.
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         irq_prev_r <= '0;
         irq_wait_r <= '0;
      end
      else
      begin
         irq_prev_r <= ~IRQ_N;
         irq_wait_r <= (irq_wait_r & ~irq_done) | irq_edge;
      end
   end

   // ------------------------------------------------------------------
   // Demand queue, messages and flags
   // ------------------------------------------------------------------
   dtd_fifo_if dq ();
   logic host_pop;
   logic msg_load;
   logic msg_valid_r;
   dtd_code_type msg_code_r;
   logic ofl_r;
   logic pend_r;

   dtd_demand_fifo #(
      .DEPTH(`DTD_DEMAND_DEPTH)
   ) u_queue (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .q(dq.fifo)
   );

   assign host_pop = rd_en && hit(acc_addr_r, `DTD_OFS_DEMAND) && !dq.empty;
   assign msg_load = demand_message_enable_r && !msg_valid_r && !dq.empty
      && !host_pop && !clr;
   assign dq.clear = clr;
   assign dq.push = push_req;
   assign dq.push_data = push_code;
   assign dq.pop = host_pop || msg_load;

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         msg_valid_r <= 1'b0;
         msg_code_r <= '0;
      end
      else if (msg_load)
      begin
         msg_valid_r <= 1'b1;
         msg_code_r <= dq.pop_data;
      end
      else if (DMD_MSG_ACCEPT)
      begin
         msg_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ofl_r <= 1'b0;
         pend_r <= 1'b0;
      end
      else
      begin
         if (push_req && dq.full)
         begin
            ofl_r <= 1'b1;
         end
         else if (clr)
         begin
            ofl_r <= 1'b0;
         end
         pend_r <= !dq.empty;
      end
   end

   assign DMD_MSG_VALID = msg_valid_r;
   assign DMD_MSG_CODE = msg_code_r;
   assign DMD_OVERFLOW = ofl_r;
   assign DMD_PENDING = pend_r;

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (rd_en)
      begin
         hrdata_r <= 32'h0000_0000;
         if (hit(acc_addr_r, `DTD_OFS_CTRL))
         begin
            hrdata_r[`DTD_CTL_OFL] <= ofl_r;
            hrdata_r[`DTD_CTL_PND] <= !dq.empty;
            hrdata_r[`DTD_CTL_DMDENA] <= demand_message_enable_r;
            hrdata_r[`DTD_CTL_INTDEN] <= interrupt_demand_enable_r;
            hrdata_r[`DTD_CTL_DLYENA] <= delay_enable_r;
            hrdata_r[`DTD_CTL_BSTENA] <= burst_enable_r;
         end
         if (hit(acc_addr_r, `DTD_OFS_XFER))
         begin
            hrdata_r <= xfer_r;
         end
         if (host_pop)
         begin
            hrdata_r[`DTD_CODE_W-1:0] <= dq.pop_data;
         end
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);

   a_ofl_set: assert property (
      push_req && dq.full |=> DMD_OVERFLOW)
      else $error("Dropped demand did not set overflow.");

   a_ofl_sticky: assert property (
      DMD_OVERFLOW && !clr |=> DMD_OVERFLOW)
      else $error("Overflow cleared without a clear write.");

   a_pend_flag: assert property (
      DMD_PENDING == !$past(dq.empty))
      else $error("Pending flag disagrees with queue state.");

   a_xfer_step: assert property (
      XFER_DONE && !CMD_LOAD && xfer_r != '0
      |=> xfer_r == $past(xfer_r) + 32'h0000_0001)
      else $error("Transfer counter did not step by one.");

   a_xfer_load: assert property (
      CMD_LOAD |=> xfer_r == $past(CMD_COUNT) ##1 XFER_RUN == (xfer_r != '0)
         || $past(XFER_DONE))
      else $error("Transfer counter did not load the command count.");

   a_msg_gate: assert property (
      $rose(DMD_MSG_VALID) |-> $past(demand_message_enable_r))
      else $error("Demand message sent while messages disabled.");

   a_burst_off: assert property (
      XFER_DONE && !CMD_LOAD && !burst_enable_r |=> BUS_RELEASE)
      else $error("Bus kept after a single transfer without bursts.");

   a_bus_wait: assert property (
      bus_take |=> !HREADYOUT ##1 HREADYOUT)
      else $error("Bus access did not take exactly one wait state.");
endmodule : dtd_regs

`default_nettype wire

// File: dtd_hwy_model.sv
`timescale 1ns/100ps
`default_nettype none

module dtd_hwy_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Demand message link
   input wire logic valid,
   input wire dtd_pkg::dtd_code_type code,
   output logic accept,
   output dtd_pkg::dtd_code_type last_code,
   output logic [7:0] got
);
   import dtd_pkg::*;
   logic [2:0] wait_r;

   // A random stall of 0 to 4 cycles keeps each message standing before it is accepted.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         accept <= 1'h0;
         wait_r <= 3'h0;
         got <= 8'h00;
         last_code <= 4'h0;
      end
      else if (accept)
         accept <= 1'h0;
      else if (valid && wait_r == 3'h0)
      begin
         accept <= 1'h1;
         last_code <= code;
         got <= got + 8'h01;
         wait_r <= 3'($urandom % 5);
      end
      else if (valid)
         wait_r <= wait_r - 3'h1;
   end
endmodule : dtd_hwy_model

`default_nettype wire

// File: dtd_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module dtd_regs_test;
   import dtd_pkg::*;
   logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, ld = 1'h0, trg = 1'h0;
   logic done = 1'h0, hrdy, run, rel, vld, acc, pnd, ofl, resp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [31:0] cnt = 32'h0000_0000, rd, hrdata;
   dtd_trig_type mask = 12'h000, trig;
   dtd_code_type mcode, lcode;
   logic [7:1] irq_n = 7'h7f;
   logic [7:0] got;
   int errors = 0, total_checks = 0, cyc = 0, nrel = 0, n, k, i, m, lvl;

   dtd_regs dut_u (.CORE_CLK(clk), .RSTN(rstn), .HSEL(1'h1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(wr), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(resp),
      .CMD_LOAD(ld), .CMD_COUNT(cnt), .BCAST_TRIG(trg), .BCAST_MASK(mask),
      .DMD_MSG_ACCEPT(acc), .DMD_MSG_VALID(vld), .DMD_MSG_CODE(mcode),
      .XFER_DONE(done), .IRQ_N(irq_n), .XFER_RUN(run), .BUS_RELEASE(rel),
      .TRIG_OUT(trig), .DMD_PENDING(pnd), .DMD_OVERFLOW(ofl));
   dtd_hwy_model hwy_u (.clk(clk), .rstn(rstn), .valid(vld), .code(mcode),
      .accept(acc), .last_code(lcode), .got(got));

   initial forever #50 clk = ~clk;

   // ----
   // Helpers
   // ----
   function int twait(int c, int en);
      return en ? 5 + 2 * c : 0;
   endfunction : twait

   function int rels(int t, int l);
      return (t + l - 1) / l;
   endfunction : rels

   task tally_and_finish;
      if (errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   // The address phase holds until hready is seen high at an edge.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      wr <= w;
      do @(posedge clk); while (hrdy !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'h1);
      rd = hrdata;
   endtask : bus

   task wrr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wrr

   task rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (rel === 1'h1)
         nrel <= nrel + 1;
      if (cyc == 40000)
      begin
         errors++;
         tally_and_finish;
      end
   end

   // ----
   // Sequence
   // ----
   initial
   begin
      void'($urandom(32'hf5ee23f4));
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      rdc(8'h00, 32'h0000_0000);
      rdc(8'h0c, 32'h0000_0000);
      n = 3 + $urandom % 4;
      k = 1 + $urandom % 3;
      wrr(8'h04, 32'h0000_ff00 | k);
      wrr(8'h00, 32'h0000_0010);
      ld <= 1'h1;
      cnt <= 32'h0000_0000 - n;
      @(posedge clk);
      ld <= 1'h0;
      i = nrel;
      for (m = 1; m <= n + 1; m++)
      begin
         done <= 1'h1;
         @(posedge clk);
         done <= 1'h0;
         repeat (2) @(posedge clk);
         if (m == n - 1)
         begin
            rdc(8'h0c, 32'hffff_ffff);
            chk(run, 1'h1);
         end
         if (m == n)
         begin
            chk(nrel - i, rels(n, k));
            wrr(8'h00, 32'h0000_0000);
         end
      end
      chk(nrel - i, rels(n, k) + 1);
      rdc(8'h0c, 32'h0000_0000);
      chk(run, 1'h0);
      for (m = 0; m < 4; m++)
      begin
         k = (m == 1) ? 0 : (m == 2) ? 1 : $urandom % 6;
         mask <= 12'($urandom) | 12'h001;
         wrr(8'h08, k);
         wrr(8'h00, m ? 32'h0000_0020 : 32'h0000_0000);
         trg <= 1'h1;
         @(posedge clk);
         trg <= 1'h0;
         n = 0;
         #1;
         while (trig === 12'h000 && n < 200)
         begin
            @(posedge clk);
            #1;
            n++;
         end
         chk(n, twait(k, m));
         chk(trig, mask);
         @(posedge clk);
         #1;
         chk(trig, mask);
         @(posedge clk);
         #1;
         chk(trig, 12'h000);
      end
      lvl = 1 + $urandom % 7;
      for (m = 0; m < 3; m++)
      begin
         wrr(8'h18, m == 1 ? 32'h7f ^ (1 << (lvl - 1)) : 32'h7f);
         wrr(8'h00, m == 2 ? 32'h0000_0280 : 32'h0000_0080);
         i = got;
         irq_n[lvl] <= 1'h0;
         repeat (20) @(posedge clk);
         irq_n[lvl] <= 1'h1;
         chk(pnd, m == 0);
         chk(got, i + (m == 2));
         if (m == 2)
            chk(lcode, lvl);
         if (m == 0)
            rdc(8'h00, 32'h0000_0480);
         rdc(8'h14, m == 0 ? lvl : 0);
         rdc(8'h14, 32'h0000_0000);
      end
      wrr(8'h18, 32'h0000_0001);
      wrr(8'h00, 32'h0000_0080);
      repeat (2049)
      begin
         irq_n[1] <= 1'h0;
         @(posedge clk);
         irq_n[1] <= 1'h1;
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk(ofl, 1'h1);
      n = 0;
      do begin bus(1'h0, 8'h14, 32'h0000_0000); n++; end
         while (rd === 32'h0000_0001 && n < 3000);
      chk(n - 1, 2048);
      chk(ofl, 1'h1);
      irq_n[1] <= 1'h0;
      repeat (4) @(posedge clk);
      irq_n[1] <= 1'h1;
      wrr(8'h00, 32'h0000_0880);
      repeat (3) @(posedge clk);
      chk(ofl, 1'h0);
      chk(pnd, 1'h0);
      rdc(8'h14, 32'h0000_0000);
      tally_and_finish;
   end
endmodule : dtd_regs_test

`default_nettype wire
